// ### pkg/ops_chan_pkg.sv
// constants, frame layout and state encodings of the operations channel handshake engine
package ops_chan_pkg;

  // ********************************************************************
  // frame layout
  // ********************************************************************
  localparam int          FRAME_W     = 13;   // address[2:0], opcode flag, parity flag, info[7:0]
  localparam int          ADDR_MSB    = 2;    // top bit of the address field
  localparam int          OPC_BIT     = 3;    // one marks opcode, zero marks data
  localparam int          PAR_BIT     = 4;    // one marks odd byte, zero marks even byte
  localparam int          INFO_LSB    = 5;    // low bit of the information field
  localparam int          INFO_MSB    = 12;   // high bit of the information field
  localparam int          BYTE_W      = 8;    // information field width
  localparam int          PAIR_W      = 2;    // wire pair number width
  localparam logic        FLAG_ONE    = 1'h1; // flag value ONE
  localparam logic        FLAG_ZERO   = 1'h0; // flag value ZERO

  // ********************************************************************
  // opcode encodings (information field, opcode flag at ONE)
  // ********************************************************************
  localparam logic [3:0]  OPC_GRP_READ  = 4'h1;  // read data, low nibble selects register
  localparam logic [3:0]  OPC_GRP_WRITE = 4'h2;  // write data, low nibble selects register
  localparam logic [7:0]  OPC_NEXT      = 8'h30; // next byte request
  localparam logic [7:0]  OPC_EOD       = 8'h31; // end of data
  localparam logic [7:0]  OPC_HOLD      = 8'h32; // hold state
  localparam logic [7:0]  OPC_RTN       = 8'h33; // return to normal
  localparam logic [7:0]  OPC_UTC       = 8'h34; // unable to comply reply

  // ********************************************************************
  // register sizes in bytes, indexed by register number
  // ********************************************************************
  localparam int          REG_NUM     = 16;
  localparam int          LEN_W       = 5;
  localparam logic [LEN_W-1:0] REG_LEN_TABLE [REG_NUM] = '{
    5'h01, 5'h02, 5'h02, 5'h04, 5'h01, 5'h02, 5'h04, 5'h08,
    5'h01, 5'h02, 5'h03, 5'h04, 5'h01, 5'h02, 5'h08, 5'h10
  };
  localparam logic [LEN_W-1:0] LEN_ZERO = 5'h00;
  localparam logic [LEN_W-1:0] LEN_ONE  = 5'h01;
  localparam logic [LEN_W-1:0] LEN_MAX  = 5'h1f;

  // ********************************************************************
  // repetition run counter and write buffer
  // ********************************************************************
  localparam logic [1:0]  RUN_ONE     = 2'h1; // first copy of a run
  localparam logic [1:0]  RUN_VALID   = 2'h3; // third identical copy, saturates here
  localparam int          WBUF_DEPTH  = 16;   // write bytes held until end of data

  // ********************************************************************
  // state encodings
  // ********************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_UTC   = 4'b1000
  } proto_state_type;

  typedef enum logic [3:0] {
    REP_ECHO = 4'b0001,
    REP_DATA = 4'b0010,
    REP_EOD  = 4'b0100,
    REP_UTC  = 4'b1000
  } reply_mode_type;

endpackage : ops_chan_pkg

// ### design/ops_sync_fifo.sv
// synchronous fifo with flush, valid and ready on both sides
`timescale 1ns/1ns
module ops_sync_fifo #(
  parameter int WIDTH = 8,   // word width
  parameter int DEPTH = 16   // number of words
) (
  input  wire logic             i_clk,       // clock
  input  wire logic             i_rst_n,     // synchronised reset, active low
  input  wire logic             i_flush,     // drop all stored words
  input  wire logic             i_in_valid,  // word offered
  output logic                  o_in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] i_in_data,   // word in
  output logic                  o_out_valid, // word available
  input  wire logic             i_out_ready, // drain side takes the word
  output logic [WIDTH-1:0]      o_out_data   // word out
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0]   CNT_FULL = PTR_W'(0) + (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_STEP = PTR_W'(1);

  // ********************************************************************
  // storage and pointers
  // ********************************************************************
  logic [WIDTH-1:0] mem_reg [DEPTH];  // word storage
  logic [PTR_W-1:0] wptr_reg;         // next write slot
  logic [PTR_W-1:0] rptr_reg;         // next read slot
  logic [PTR_W:0]   cnt_reg;          // words held

  wire do_push = i_in_valid && o_in_ready;     // accepted write
  wire do_pop  = o_out_valid && i_out_ready; // accepted read

  assign o_in_ready  = (cnt_reg != CNT_FULL);
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rptr_reg];

  // pointer and count update; flush wins over both sides
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else if (i_flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (do_push) wptr_reg <= wptr_reg + PTR_STEP;
      if (do_pop)  rptr_reg <= rptr_reg + PTR_STEP;
      cnt_reg <= cnt_reg + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (do_push) mem_reg[wptr_reg] <= i_in_data;
  end

endmodule : ops_sync_fifo

// ### design/ops_channel_register_read_write.sv
// operations channel slave: echo handshake, register byte read and write, unable-to-comply
`timescale 1ns/1ns
module ops_channel_register_read_write
  import ops_chan_pkg::*;
(
  input  wire logic               i_clk,       // 100 MHz clock
  input  wire logic               i_rst_n,     // asynchronous reset, active low
  input  wire logic               i_rx_valid,  // one-cycle strobe: a frame arrived
  input  wire logic [FRAME_W-1:0] i_rx_frame,  // received frame
  input  wire logic [PAIR_W-1:0]  i_rx_pair,   // pair the frame came over
  output logic                    o_tx_valid,  // one-cycle strobe: reply ready
  output logic [FRAME_W-1:0]      o_tx_frame,  // reply frame
  output logic [3:0]              o_rd_sel,    // register being read
  output logic [LEN_W-1:0]        o_rd_idx,    // byte index being read
  input  wire logic [BYTE_W-1:0]  i_rd_data,   // byte at o_rd_sel/o_rd_idx
  output logic                    o_wr_valid,  // committed write byte valid
  output logic [3:0]              o_wr_sel,    // register being written
  output logic [LEN_W-1:0]        o_wr_idx,    // byte index being written
  output logic [BYTE_W-1:0]       o_wr_data,   // byte being written
  input  wire logic               i_wr_ready,  // register file takes the byte
  output logic                    o_utc_state  // unable-to-comply state active
);

  // ********************************************************************
  // reset release
  // ********************************************************************
  logic rst_meta_reg;  // first stage, read only by the second
  logic rst_sync_reg;  // reset copy used by the design
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // ********************************************************************
  // state
  // ********************************************************************
  proto_state_type     state_reg, state_next;   // protocol state
  reply_mode_type      mode_reg, mode_next;     // reply kept for the rest of a run
  logic [FRAME_W-1:0]  last_frame_reg;          // previous frame
  logic [PAIR_W-1:0]   last_pair_reg;           // pair of previous frame
  logic [1:0]          run_reg;                 // identical copies so far
  logic [3:0]          sel_reg, sel_next;       // addressed register
  logic [LEN_W-1:0]    idx_reg, idx_next;       // next byte to read
  logic                exp_reg, exp_next;       // parity expected for a new byte
  logic [BYTE_W-1:0]   data_reg, data_next;     // last byte served
  logic [LEN_W-1:0]    wcnt_reg, wcnt_next;     // write bytes accepted
  logic                ovf_reg, ovf_next;       // write buffer overran
  logic                commit_reg, commit_next; // draining buffer into register
  logic                flush;                   // drop buffered write bytes
  logic                push;                    // store a write byte
  logic                tx_valid_reg;            // reply strobe
  logic [FRAME_W-1:0]  tx_frame_reg;            // reply frame
  logic                wr_valid_reg;            // write byte strobe
  logic [3:0]          wr_sel_reg;              // register under commit
  logic [LEN_W-1:0]    wr_idx_reg;              // byte index under commit
  logic [BYTE_W-1:0]   wr_data_reg;             // byte under commit
  logic                utc_reg;                 // unable-to-comply flag

  // ********************************************************************
  // frame decode
  // ********************************************************************
  wire [BYTE_W-1:0] info     = i_rx_frame[INFO_MSB:INFO_LSB];
  wire              is_opc   = (i_rx_frame[OPC_BIT] == FLAG_ONE);
  wire              par      = i_rx_frame[PAR_BIT];
  wire              is_read  = is_opc && (info[7:4] == OPC_GRP_READ);
  wire              is_write = is_opc && (info[7:4] == OPC_GRP_WRITE);
  wire              is_next  = is_opc && (info == OPC_NEXT);
  wire              is_eod   = is_opc && (info == OPC_EOD);
  wire              is_rtn   = is_opc && (info == OPC_RTN);
  wire              is_leave = is_opc && ((info == OPC_HOLD) || is_rtn);

  // ********************************************************************
  // repetition run: same frame over the same pair
  // ********************************************************************
  wire       same    = (i_rx_frame == last_frame_reg) && (i_rx_pair == last_pair_reg);
  wire [1:0] run_new = !same ? RUN_ONE :
                       (run_reg == RUN_VALID) ? RUN_VALID : run_reg + RUN_ONE;
  wire       run3    = (run_new == RUN_VALID);
  // acts once per run, on exactly the third copy
  wire       third   = i_rx_valid && run3 && !(same && (run_reg == RUN_VALID));
  wire [LEN_W-1:0] len_sel = REG_LEN_TABLE[sel_reg];

  // ********************************************************************
  // write buffer and commit drain
  // ********************************************************************
  logic              wbuf_in_ready;   // room in buffer
  logic              wbuf_out_valid;  // buffered byte present
  logic [BYTE_W-1:0] wbuf_out_data;   // oldest buffered byte
  // back-pressure from the register file stalls the drain
  wire wbuf_pop = commit_reg && wbuf_out_valid && (!wr_valid_reg || i_wr_ready);

  ops_sync_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .i_clk         (i_clk),
    .i_rst_n       (rst_n),
    .i_flush       (flush),
    .i_in_valid    (push),
    .o_in_ready    (wbuf_in_ready),
    .i_in_data     (info),
    .o_out_valid   (wbuf_out_valid),
    .i_out_ready   (wbuf_pop),
    .o_out_data    (wbuf_out_data)
  );

  // ********************************************************************
  // protocol decisions, taken on the third identical copy
  // ********************************************************************
  always_comb begin
    state_next  = state_reg;
    mode_next   = mode_reg;
    sel_next    = sel_reg;
    idx_next    = idx_reg;
    exp_next    = exp_reg;
    data_next   = data_reg;
    wcnt_next   = wcnt_reg;
    ovf_next    = ovf_reg;
    commit_next = commit_reg && wbuf_out_valid; // ends once buffer is drained
    flush       = 1'b0;
    push        = 1'b0;
    if (third) begin
      mode_next = REP_ECHO;
      case (state_reg)
        ST_IDLE: begin
          if (is_read) begin
            state_next = ST_READ;
            sel_next   = info[3:0];
            idx_next   = LEN_ZERO;
            exp_next   = FLAG_ONE;
          end else if (is_write) begin
            state_next = ST_WRITE;
            sel_next   = info[3:0];
            wcnt_next  = LEN_ZERO;
            ovf_next   = 1'b0;
            exp_next   = FLAG_ONE;
          end else if (!is_leave) begin // data or any opcode but read, write, Hold or Return: cannot comply
            state_next = ST_UTC;
            mode_next  = REP_UTC;
          end
        end
        ST_READ: begin
          if (is_next && (par == exp_reg)) begin
            exp_next = ~exp_reg;
            if (idx_reg < len_sel) begin
              data_next = i_rd_data;
              idx_next  = idx_reg + LEN_ONE;
              mode_next = REP_DATA;
            end else begin
              mode_next = REP_EOD;
            end
          end else if (is_next) begin
            mode_next = (idx_reg == LEN_ZERO) ? REP_ECHO : REP_DATA; // data reply: third copy carries the byte at idx_reg, later copies data_reg
          end else if (is_leave) begin
            state_next = ST_IDLE;
          end else begin
            state_next = ST_UTC;
            mode_next  = REP_UTC;
          end
        end
        ST_WRITE: begin
          if (!is_opc) begin
            if (par == exp_reg) begin
              push      = 1'b1;
              ovf_next  = ovf_reg || !wbuf_in_ready; // extra bytes overflow the buffer
              wcnt_next = (wcnt_reg == LEN_MAX) ? LEN_MAX : wcnt_reg + LEN_ONE;
              exp_next  = ~exp_reg;
            end
          end else if (is_eod) begin
            state_next = ST_IDLE;
            if ((wcnt_reg == len_sel) && !ovf_reg) begin
              commit_next = 1'b1;
            end else begin
              state_next = ST_UTC;
              mode_next  = REP_UTC;
              flush      = 1'b1;
            end
          end else if (is_leave) begin
            state_next = ST_IDLE;
            flush      = 1'b1;
          end else begin
            state_next = ST_UTC;
            mode_next  = REP_UTC;
            flush      = 1'b1;
          end
        end
        ST_UTC: begin
          if (is_rtn) begin
            state_next = ST_IDLE;
          end else begin
            mode_next = REP_UTC;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // reply selection: echo until the third copy (unable-to-comply while in ST_UTC), then the decided reply
  // ********************************************************************
  wire reply_mode_type rep_eff = third ? mode_next :
                                 run3 ? mode_reg :
                                 (state_reg == ST_UTC) ? REP_UTC : REP_ECHO;
  wire [BYTE_W-1:0]    rep_byte = third ? i_rd_data : data_reg;
  wire [ADDR_MSB:0]    addr     = i_rx_frame[ADDR_MSB:0];
  wire [FRAME_W-1:0]   frm_data = {rep_byte, par, FLAG_ZERO, addr};
  wire [FRAME_W-1:0]   frm_eod  = {OPC_EOD, par, FLAG_ONE, addr};
  wire [FRAME_W-1:0]   frm_utc  = {OPC_UTC, par, FLAG_ONE, addr};
  wire [FRAME_W-1:0]   rep_frame = (rep_eff == REP_DATA) ? frm_data :
                                   (rep_eff == REP_EOD)  ? frm_eod  :
                                   (rep_eff == REP_UTC)  ? frm_utc  : i_rx_frame;

  // ********************************************************************
  // protocol registers
  // ********************************************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      mode_reg   <= REP_ECHO;
      sel_reg    <= '0;
      idx_reg    <= LEN_ZERO;
      exp_reg    <= FLAG_ONE;
      data_reg   <= '0;
      wcnt_reg   <= LEN_ZERO;
      ovf_reg    <= 1'b0;
      commit_reg <= 1'b0;
      utc_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      mode_reg   <= mode_next;
      sel_reg    <= sel_next;
      idx_reg    <= idx_next;
      exp_reg    <= exp_next;
      data_reg   <= data_next;
      wcnt_reg   <= wcnt_next;
      ovf_reg    <= ovf_next;
      commit_reg <= commit_next;
      utc_reg    <= (state_next == ST_UTC);
    end
  end

  // run tracker; from reset a matching first frame still counts as one
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_frame_reg <= '0;
      last_pair_reg  <= '0;
      run_reg        <= '0;
    end else if (i_rx_valid) begin
      last_frame_reg <= i_rx_frame;
      last_pair_reg  <= i_rx_pair;
      run_reg        <= run_new;
    end
  end

  // reply goes out the cycle after reception, the next return slot
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_reg <= 1'b0;
      tx_frame_reg <= '0;
    end else begin
      tx_valid_reg <= i_rx_valid;
      if (i_rx_valid) tx_frame_reg <= rep_frame;
    end
  end

  // commit port: holds a byte until the register file takes it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_reg <= 1'b0;
      wr_sel_reg   <= '0;
      wr_idx_reg   <= LEN_ZERO;
      wr_data_reg  <= '0;
    end else begin
      if (commit_next && !commit_reg) begin
        wr_sel_reg <= sel_reg;
        wr_idx_reg <= LEN_ZERO;
      end else if (wr_valid_reg && i_wr_ready) begin
        wr_idx_reg <= wr_idx_reg + LEN_ONE;
      end
      if (wbuf_pop) begin
        wr_valid_reg <= 1'b1;
        wr_data_reg  <= wbuf_out_data;
      end else if (i_wr_ready) begin
        wr_valid_reg <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // outputs, all from flip-flops
  // ********************************************************************
  assign o_tx_valid  = tx_valid_reg;
  assign o_tx_frame  = tx_frame_reg;
  assign o_rd_sel    = sel_reg;
  assign o_rd_idx    = idx_reg;
  assign o_wr_valid  = wr_valid_reg;
  assign o_wr_sel    = wr_sel_reg;
  assign o_wr_idx    = wr_idx_reg;
  assign o_wr_data   = wr_data_reg;
  assign o_utc_state = utc_reg;

endmodule : ops_channel_register_read_write

// ### verification/ops_chan_props.sv
// concurrent checks on the ports of the operations channel slave
`timescale 1ns/1ns
module ops_chan_props
  import ops_chan_pkg::*;
(
  input wire logic               i_clk,       // clock
  input wire logic               i_rst_n,     // reset, active low
  input wire logic               i_rx_valid,  // frame in
  input wire logic [FRAME_W-1:0] i_rx_frame,  // received frame
  input wire logic [PAIR_W-1:0]  i_rx_pair,   // pair of frame
  input wire logic               o_tx_valid,  // reply strobe
  input wire logic [FRAME_W-1:0] o_tx_frame,  // reply frame
  input wire logic               o_wr_valid,  // commit offered
  input wire logic [LEN_W-1:0]   o_wr_idx,    // commit index
  input wire logic [BYTE_W-1:0]  o_wr_data,   // commit byte
  input wire logic               i_wr_ready,  // commit taken
  input wire logic               o_utc_state  // unable-to-comply
);
  // ********************************************************************
  // run tracking: a pair change breaks a run just as a frame change does
  // ********************************************************************
  logic [FRAME_W-1:0] last_f_reg;  // previous frame
  logic [PAIR_W-1:0]  last_p_reg;  // previous pair
  logic [1:0]         run_reg;     // copies so far, zero before any
  wire same = run_reg != 2'h0 && i_rx_frame == last_f_reg && i_rx_pair == last_p_reg;
  wire [1:0] run_next = !same ? RUN_ONE : (run_reg == RUN_VALID) ? RUN_VALID : run_reg + 2'h1;
  wire third_rx = i_rx_valid && run_next == RUN_VALID;  // confirmed copy
  wire rtn_msg = i_rx_frame[INFO_MSB:INFO_LSB] == OPC_RTN && i_rx_frame[OPC_BIT];
  // follow the run of identical frames
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= 2'h0;
      last_f_reg <= '0;
      last_p_reg <= '0;
    end else if (i_rx_valid) begin
      run_reg <= run_next;
      last_f_reg <= i_rx_frame;
      last_p_reg <= i_rx_pair;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rtn_third;
    third_rx && rtn_msg;
  endsequence
  tx_follows_rx_a: assert property (i_rx_valid |=> o_tx_valid)
    else $error("reply missing after a frame");
  tx_needs_rx_a: assert property (o_tx_valid |-> $past(i_rx_valid))
    else $error("reply without a frame");
  early_echo_a: assert property (i_rx_valid && !third_rx && !o_utc_state
    |=> o_tx_frame == $past(i_rx_frame)) else $error("first copies not echoed");
  par_copy_a: assert property (o_tx_valid |-> o_tx_frame[PAR_BIT] == $past(i_rx_frame[PAR_BIT]))
    else $error("reply parity differs from request");
  utc_reply_a: assert property (i_rx_valid && o_utc_state && !(third_rx && rtn_msg)
    |=> o_tx_frame[INFO_MSB:INFO_LSB] == OPC_UTC) else $error("no refusal reply");
  utc_exit_a: assert property ((o_utc_state ##0 s_rtn_third) |=> !o_utc_state)
    else $error("refusal state kept after return to normal");
  utc_hold_a: assert property (o_utc_state && !(third_rx && rtn_msg) |=> o_utc_state)
    else $error("refusal state left early");
  utc_entry_a: assert property ($rose(o_utc_state) |-> $past(third_rx))
    else $error("refusal state without a confirmed frame");
  commit_hold_a: assert property (o_wr_valid && !i_wr_ready
    |=> o_wr_valid && $stable(o_wr_data) && $stable(o_wr_idx)) else $error("commit byte dropped");
  utc_no_commit_a: assert property (o_utc_state |-> !o_wr_valid)
    else $error("commit during refusal state");
endmodule : ops_chan_props
bind ops_channel_register_read_write ops_chan_props i_ops_chan_props (.i_clk, .i_rst_n,
  .i_rx_valid, .i_rx_frame, .i_rx_pair, .o_tx_valid, .o_tx_frame, .o_wr_valid, .o_wr_idx,
  .o_wr_data, .i_wr_ready, .o_utc_state);

// ### verification/ops_regfile_model.sv
// register file behind the slave's read and commit ports, stalling commits at random
`timescale 1ns/1ns
module ops_regfile_model
  import ops_chan_pkg::*;
(
  input  wire logic              i_clk,      // clock
  input  wire logic [3:0]        i_rd_sel,   // register read
  input  wire logic [LEN_W-1:0]  i_rd_idx,   // byte index read
  output logic      [BYTE_W-1:0] o_rd_data,  // byte returned
  input  wire logic              i_wr_valid, // commit byte offered
  input  wire logic [3:0]        i_wr_sel,   // register written
  input  wire logic [LEN_W-1:0]  i_wr_idx,   // byte index written
  input  wire logic [BYTE_W-1:0] i_wr_data,  // byte written
  output logic                   o_wr_ready  // byte taken
);
  logic [BYTE_W-1:0] mem [16][16];  // contents, preset to a known pattern
  int                seed = 60;     // stall pattern seed
  initial begin
    o_wr_ready = 1'h0;
    for (int s = 0; s < 16; s++) for (int i = 0; i < 16; i++) mem[s][i] = 8'(s * 16 + i) ^ 8'h5a;
  end
  // index wraps past the last byte: the slave must not use it then
  assign o_rd_data = mem[i_rd_sel][i_rd_idx[3:0]];
  // a third of the cycles refuse the commit byte
  always @(posedge i_clk) begin
    o_wr_ready <= ($random(seed) % 3) != 0;
    if (i_wr_valid && o_wr_ready) mem[i_wr_sel][i_wr_idx[3:0]] <= i_wr_data;
  end
endmodule : ops_regfile_model

// ### verification/ops_channel_register_read_write_tb_top.sv
// self-checking bench for the operations channel slave
`timescale 1ns/1ns
module ops_channel_register_read_write_tb_top
  import ops_chan_pkg::*;
;
  logic               i_clk, i_rst_n, i_rx_valid, o_tx_valid, o_wr_valid, i_wr_ready, o_utc_state;
  logic [FRAME_W-1:0] i_rx_frame, o_tx_frame;
  logic [PAIR_W-1:0]  i_rx_pair;
  logic [3:0]         o_rd_sel, o_wr_sel;
  logic [LEN_W-1:0]   o_rd_idx, o_wr_idx;
  logic [BYTE_W-1:0]  i_rd_data, o_wr_data;
  logic [2:0]         ad;                  // address carried by every frame
  int                 n_mismatch, comparisons, seed;
  int                 exp_mem [16][16];    // expected register contents
  ops_channel_register_read_write i_ops_channel_register_read_write (.i_clk, .i_rst_n,
    .i_rx_valid, .i_rx_frame, .i_rx_pair, .o_tx_valid, .o_tx_frame, .o_rd_sel, .o_rd_idx,
    .i_rd_data, .o_wr_valid, .o_wr_sel, .o_wr_idx, .o_wr_data, .i_wr_ready, .o_utc_state);
  ops_regfile_model i_ops_regfile_model (.i_clk, .i_rd_sel(o_rd_sel), .i_rd_idx(o_rd_idx),
    .o_rd_data(i_rd_data), .i_wr_valid(o_wr_valid), .i_wr_sel(o_wr_sel), .i_wr_idx(o_wr_idx),
    .i_wr_data(o_wr_data), .o_wr_ready(i_wr_ready));
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [12:0] mk(input logic [7:0] i, input logic par, input logic opc);
    return {i, par, opc, ad};
  endfunction : mk
  // one frame in, its reply checked in the following cycle; the line then shows garbage
  task automatic xfer(input logic [12:0] f, input logic [12:0] e, input logic [1:0] p);
    @(posedge i_clk); #1 {i_rx_valid, i_rx_frame, i_rx_pair} = {1'h1, f, p};
    @(posedge i_clk); #1 {i_rx_valid, i_rx_frame} = {1'h0, ~f};
    chk("tx_valid", 1, o_tx_valid);
    chk("tx_frame", e, o_tx_frame);
  endtask : xfer
  task automatic rep3(input logic [12:0] f, e12, e3, input logic [1:0] p);
    xfer(f, e12, p);
    xfer(f, e12, p);
    xfer(f, e3, p);
  endtask : rep3
  task automatic leave_utc();
    rep3(mk(OPC_RTN, 1, 1), mk(OPC_UTC, 1, 1), mk(OPC_RTN, 1, 1), 0);
    chk("utc_state", 0, o_utc_state);
  endtask : leave_utc
  task automatic rd(input int r);
    logic [12:0] f, e;
    logic [1:0]  p;
    p = 2'($random(seed));
    f = mk({OPC_GRP_READ, 4'(r)}, 1, 1);
    rep3(f, f, f, p);
    for (int b = 0; b <= REG_LEN_TABLE[r]; b++) begin
      f = mk(OPC_NEXT, ~b[0], 1);
      e = b < REG_LEN_TABLE[r] ? mk(8'(exp_mem[r][b]), ~b[0], 0) : mk(OPC_EOD, ~b[0], 1);
      if (b == 0) xfer(f, f, ~p);
      rep3(f, f, e, p);
      xfer(f, e, p);
      xfer(f, e, p);
    end
    f = mk(r[0] ? OPC_RTN : OPC_HOLD, 1, 1);
    rep3(f, f, f, p);
  endtask : rd
  task automatic wr(input int r, input int n);
    logic [12:0] f;
    logic [1:0]  p;
    int          q [$];
    int          k;
    p = 2'($random(seed));
    f = mk({OPC_GRP_WRITE, 4'(r)}, 1, 1);
    rep3(f, f, f, p);
    for (int b = 0; b < n; b++) begin
      q.push_back($random(seed) & 255);
      f = mk(8'(q[b]), ~b[0], 0);
      rep3(f, f, f, p);
    end
    f = mk(OPC_EOD, 1, 1);
    rep3(f, f, n == REG_LEN_TABLE[r] ? f : mk(OPC_UTC, 1, 1), p);
    chk("utc_state", n != REG_LEN_TABLE[r], o_utc_state);
    k = 0;
    for (int c = 0; c < 200 && k < q.size(); c++) begin
      @(posedge i_clk); #1;
      if (o_wr_valid === 1'h1 && i_wr_ready === 1'h1) begin
        chk("wr_sel", r, o_wr_sel);
        chk("wr_idx", k, o_wr_idx);
        chk("wr_data", q[k], o_wr_data);
        if (n == REG_LEN_TABLE[r]) exp_mem[r][k] = q[k];
        k++;
      end
    end
    chk("commit_count", n == REG_LEN_TABLE[r] ? n : 0, k);
    if (n != REG_LEN_TABLE[r]) leave_utc();
  endtask : wr
  initial begin
    seed = 60;
    {i_rst_n, i_rx_valid, i_rx_frame, i_rx_pair} = '0;
    for (int s = 0; s < 16; s++) for (int i = 0; i < 16; i++) exp_mem[s][i] = (s * 16 + i) ^ 8'h5a;
    ad = 3'($random(seed));
    repeat (4) @(posedge i_clk);
    #1 i_rst_n = 1'h1;
    repeat (3) @(posedge i_clk);
    for (int r = 0; r < 16; r++) rd(r);
    for (int r = 0; r < 16; r++) begin
      wr(r, REG_LEN_TABLE[r]);
      rd(r);
    end
    wr(3, 1);
    wr(2, 3);
    rd(3);
    rep3(mk(8'h25, 1, 1), mk(8'h25, 1, 1), mk(8'h25, 1, 1), 0);
    rep3(mk(OPC_RTN, 1, 1), mk(OPC_RTN, 1, 1), mk(OPC_RTN, 1, 1), 0);
    rep3(mk(8'h10, 1, 1), mk(8'h10, 1, 1), mk(8'h10, 1, 1), 0);
    rep3(mk(8'h21, 1, 1), mk(8'h21, 1, 1), mk(OPC_UTC, 1, 1), 0);
    leave_utc();
    print_verdict();
  end
  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end
endmodule : ops_channel_register_read_write_tb_top
